// ---- logic/power_telemetry_readback.sv ----
// read-only status and telemetry command bank of a dual channel controller
// Functional notes
// RULE_01: the common status byte is a one byte read of alert, busy, pending, transition, memory ready, timebase timeout and write protect bits.
// RULE_02: the extended info word is a two byte read whose bit 5 is 1 when no memory ECC corrections were made and all other bits are zero.
// RULE_03: the ECC flag is refreshed on power-on reset, restore, reset command and memory bulk read.
// RULE_04: code 0x88 returns unpaged input voltage as an L11 word.
// RULE_05: code 0x8B returns paged output voltage as unsigned L16 scaled by the channel's mode exponent.
// RULE_06: code 0x89 returns total input current as the sum of both channel input currents.
// RULE_07: code 0xED returns per page the offset plus output current times duty cycle.
// RULE_08: code 0x8C returns paged output current from sense voltage, gain, gain temperature coefficient and corrected external temperature.
// RULE_09: code 0x8D returns paged corrected external temperature, which also drives current calibration.
// RULE_10: code 0x8E returns internal temperature, which influences no other register.
// RULE_11: codes 0x94 and 0x96 return paged duty cycle and output power as L11 words.
// RULE_12: paged running maxima of output voltage (0xDD, L16) and output current (0xD7, L11) follow each measurement.
// RULE_13: running maxima of input voltage (0xDE), external temperature (0xDF, paged) and internal temperature (0xF4) are kept in L11.
// RULE_14: every telemetry read is a read-only two byte word, L11 except output voltage and its maximum which are L16.
// RULE_15: the peak clear command empties every stored maximum, except that a sample landing in the same cycle loads it instead.
module power_telemetry_readback
  import telemetry_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             cmd_read,
  input  wire logic             cmd_send,
  input  wire logic [7:0]       cmd_code,
  input  wire logic             cmd_page,
  input  wire logic             sample_valid,
  input  wire logic [15:0]      vin_sample,
  input  wire logic [15:0]      int_temp_sample,
  input  wire logic [1:0][15:0] vout_sample,
  input  wire logic [1:0][15:0] vsense_sample,
  input  wire logic [1:0][15:0] ext_diode_sample,
  input  wire logic [1:0][15:0] duty_sample,
  input  wire logic [1:0][15:0] current_cal_gain,
  input  wire logic [1:0][15:0] current_gain_temp_coeff,
  input  wire logic [1:0][15:0] ext_temp_gain,
  input  wire logic [1:0][15:0] ext_temp_offset,
  input  wire logic [1:0][15:0] input_current_offset,
  input  wire logic [1:0][4:0]  vout_mode_exp,
  input  wire logic             alert_driving_low,
  input  wire logic             device_busy,
  input  wire logic             output_in_transition,
  input  wire logic             nvm_initialized,
  input  wire logic             shared_timebase_line_timeout,
  input  wire logic             write_protect_pin,
  input  wire logic             ecc_no_corrections,
  input  wire logic             restore_event,
  input  wire logic             reset_cmd_event,
  input  wire logic             bulk_read_event,
  output      logic [15:0]      read_data,
  output      logic             read_valid,
  output      logic             read_two_bytes,
  output      logic             read_unsupported
);

  // ---------------------------------------------------------------
  // number format helpers
  // ---------------------------------------------------------------
  // linear 5s/11s word to signed fixed point with 16 fraction bits
  function automatic fix_t l11_to_fix(input logic [15:0] w);
    logic signed [4:0] e;
    fix_t              m;
    e = w[15:11];
    m = fix_t'($signed(w[10:0]));
    return m <<< (int'(e) + L11_EXP_BIAS);
  endfunction : l11_to_fix

  // smallest exponent that keeps the mantissa within eleven bits
  function automatic logic [15:0] fix_to_l11(input fix_t v);
    fix_t        t;
    logic        done;
    logic [15:0] r;
    done = 1'b0;
    r    = (v < 0) ? L11_SATURATE_NEG : L11_SATURATE_POS;
    for (int s = 0; s < L11_MAX_SH; s++) begin
      t = v >>> s;
      if (!done && t >= -1024 && t <= 1023) begin
        r    = {5'(s - L11_EXP_BIAS), t[10:0]};
        done = 1'b1;
      end
    end
    return r;
  endfunction : fix_to_l11

  function automatic fix_t mul_fix(input fix_t a, input fix_t b);
    wide_t p;
    p = wide_t'(a) * wide_t'(b);
    return fix_t'(p >>> FIX_FRAC);
  endfunction : mul_fix

  // raw output voltage in 2^-12 volt steps to unsigned L16 at mode exponent
  function automatic logic [15:0] vout_to_l16(input logic [15:0] s,
                                              input logic [4:0]  e);
    logic signed [6:0] sh;
    logic [31:0]       w;
    sh = -7'sd12 - 7'($signed(e));
    w  = {16'h0000, s};
    if (sh >= 0)
      w = w << sh;
    else
      w = w >> (-sh);
    return (w[31:16] != 16'h0000) ? 16'hFFFF : w[15:0];
  endfunction : vout_to_l16

  function automatic logic l11_above(input logic [15:0] a,
                                     input logic [15:0] b);
    return l11_to_fix(a) > l11_to_fix(b);
  endfunction : l11_above

  // ---------------------------------------------------------------
  // measurement pipeline
  // ---------------------------------------------------------------
  logic             s1_valid;
  logic             s2_valid;
  fix_t             temp_fix [2];
  fix_t             r_eff    [2];
  logic [15:0]      vin_s;
  logic [15:0]      int_temp_s;
  logic [1:0][15:0] vout_s;
  logic [1:0][15:0] vsense_s;
  logic [1:0][15:0] duty_s;

  // stage one latches the sample and corrects the diode temperature
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_valid   <= 1'b0;
      vin_s      <= WORD_RESET;
      int_temp_s <= WORD_RESET;
      vout_s     <= '0;
      vsense_s   <= '0;
      duty_s     <= '0;
      temp_fix   <= '{default: '0};
    end else begin
      s1_valid <= sample_valid;
      if (sample_valid) begin
        vin_s      <= vin_sample;
        int_temp_s <= int_temp_sample;
        vout_s     <= vout_sample;
        vsense_s   <= vsense_sample;
        duty_s     <= duty_sample;
        for (int ch = 0; ch < 2; ch++)
          temp_fix[ch] <= mul_fix(l11_to_fix(ext_diode_sample[ch]),
                                  l11_to_fix(ext_temp_gain[ch]))
                          + l11_to_fix(ext_temp_offset[ch]);   // RULE_09
      end
    end
  end

  // stage two scales the sense resistance by its temperature drift
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s2_valid <= 1'b0;
      r_eff    <= '{default: '0};
    end else begin
      s2_valid <= s1_valid;
      if (s1_valid) begin
        for (int ch = 0; ch < 2; ch++)
          r_eff[ch] <= mul_fix(l11_to_fix(current_cal_gain[ch]),
                       FIX_ONE + fix_t'((wide_t'($signed(
                       current_gain_temp_coeff[ch]))
                       * wide_t'(temp_fix[ch] - REF_TEMP_FIX)
                       * wide_t'(PPM_RECIP)) >>> PPM_SHIFT));  // RULE_08
      end
    end
  end

  // stage three: currents, power and formatted words
  fix_t        iout_fix [2];
  fix_t        iin_fix  [2];
  logic [15:0] next_iout   [2];
  logic [15:0] next_iin    [2];
  logic [15:0] next_pout   [2];
  logic [15:0] next_vout   [2];
  logic [15:0] next_iin_total;
  always_comb begin
    wide_t num;
    num = '0;
    for (int ch = 0; ch < 2; ch++) begin
      num = (wide_t'(l11_to_fix(vsense_s[ch])) * wide_t'(OHM_PER_MILLI))
            <<< FIX_FRAC;
      // a zero or negative gain would divide by zero: report no current
      iout_fix[ch] = (r_eff[ch] > 0) ? fix_t'(num / wide_t'(r_eff[ch]))
                                     : '0;                     // RULE_08
      iin_fix[ch]  = l11_to_fix(input_current_offset[ch])
                     + mul_fix(mul_fix(iout_fix[ch],
                                       l11_to_fix(duty_s[ch])),
                               PCT_RECIP);                     // RULE_07
      next_iout[ch] = fix_to_l11(iout_fix[ch]);
      next_iin[ch]  = fix_to_l11(iin_fix[ch]);
      next_pout[ch] = fix_to_l11(mul_fix(
                        fix_t'({vout_s[ch], 4'h0}),
                        iout_fix[ch]));                        // RULE_11
      next_vout[ch] = vout_to_l16(vout_s[ch], vout_mode_exp[ch]); // RULE_05
    end
    next_iin_total = fix_to_l11(iin_fix[0] + iin_fix[1]);      // RULE_06
  end

  // ---------------------------------------------------------------
  // reading and running maximum registers
  // ---------------------------------------------------------------
  logic [15:0] input_voltage_reading;
  logic [15:0] input_current_total;
  logic [15:0] internal_temp_reading;
  logic [15:0] input_voltage_max;
  logic [15:0] internal_temp_max;
  logic [15:0] output_voltage_reading [2];
  logic [15:0] output_current_reading [2];
  logic [15:0] external_temp_reading  [2];
  logic [15:0] duty_cycle_reading     [2];
  logic [15:0] output_power_reading   [2];
  logic [15:0] channel_input_current  [2];
  logic [15:0] output_voltage_max     [2];
  logic [15:0] output_current_max     [2];
  logic [15:0] external_temp_max      [2];
  logic [2:0]  peak_loaded;
  logic [1:0]  chan_peak_loaded;
  logic        peak_clear;

  assign peak_clear = cmd_send && (cmd_code == CODE_PEAK_CLEAR);

  // readings refresh together once the pipeline finishes a sample
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      input_voltage_reading  <= WORD_RESET;
      input_current_total    <= WORD_RESET;
      internal_temp_reading  <= WORD_RESET;
      output_voltage_reading <= '{default: WORD_RESET};
      output_current_reading <= '{default: WORD_RESET};
      external_temp_reading  <= '{default: WORD_RESET};
      duty_cycle_reading     <= '{default: WORD_RESET};
      output_power_reading   <= '{default: WORD_RESET};
      channel_input_current  <= '{default: WORD_RESET};
    end else if (s2_valid) begin
      input_voltage_reading <= vin_s;                          // RULE_04
      input_current_total   <= next_iin_total;                 // RULE_06
      internal_temp_reading <= int_temp_s;                     // RULE_10
      for (int ch = 0; ch < 2; ch++) begin
        output_voltage_reading[ch] <= next_vout[ch];           // RULE_05
        output_current_reading[ch] <= next_iout[ch];           // RULE_08
        external_temp_reading[ch]  <= fix_to_l11(temp_fix[ch]); // RULE_09
        duty_cycle_reading[ch]     <= duty_s[ch];              // RULE_11
        output_power_reading[ch]   <= next_pout[ch];           // RULE_11
        channel_input_current[ch]  <= next_iin[ch];            // RULE_07
      end
    end
  end

  // an emptied maximum takes the next sample whatever its value;
  // a sample landing with the clear is kept rather than lost
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      input_voltage_max  <= WORD_RESET;
      internal_temp_max  <= WORD_RESET;
      output_voltage_max <= '{default: WORD_RESET};
      output_current_max <= '{default: WORD_RESET};
      external_temp_max  <= '{default: WORD_RESET};
      peak_loaded        <= 3'h0;
      chan_peak_loaded   <= 2'h0;
    end else if (s2_valid) begin
      peak_loaded <= 3'h7;
      chan_peak_loaded <= 2'h3;
      if (peak_clear || !peak_loaded[0] ||
          l11_above(vin_s, input_voltage_max))
        input_voltage_max <= vin_s;                            // RULE_13
      if (peak_clear || !peak_loaded[1] ||
          l11_above(int_temp_s, internal_temp_max))
        internal_temp_max <= int_temp_s;                       // RULE_13
      for (int ch = 0; ch < 2; ch++) begin
        if (peak_clear || !chan_peak_loaded[ch] ||
            next_vout[ch] > output_voltage_max[ch])
          output_voltage_max[ch] <= next_vout[ch];             // RULE_12
        if (peak_clear || !chan_peak_loaded[ch] ||
            l11_above(next_iout[ch], output_current_max[ch]))
          output_current_max[ch] <= next_iout[ch];             // RULE_12
        if (peak_clear || !chan_peak_loaded[ch] ||
            l11_above(fix_to_l11(temp_fix[ch]), external_temp_max[ch]))
          external_temp_max[ch] <= fix_to_l11(temp_fix[ch]);   // RULE_13
      end
    end else if (peak_clear) begin
      input_voltage_max  <= WORD_RESET;                        // RULE_15
      internal_temp_max  <= WORD_RESET;
      output_voltage_max <= '{default: WORD_RESET};
      output_current_max <= '{default: WORD_RESET};
      external_temp_max  <= '{default: WORD_RESET};
      peak_loaded        <= 3'h0;
      chan_peak_loaded   <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // status bits
  // ---------------------------------------------------------------
  logic ecc_clean;
  logic por_pending;

  // the power-on capture happens on the first edge after release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ecc_clean   <= ECC_CLEAN_RESET;
      por_pending <= 1'b1;
    end else begin
      por_pending <= 1'b0;
      if (por_pending || restore_event || reset_cmd_event ||
          bulk_read_event)
        ecc_clean <= ecc_no_corrections;                       // RULE_03
    end
  end

  logic        calc_pending;
  logic [7:0]  common_status_byte;
  logic [15:0] extended_info_word;
  assign calc_pending = sample_valid || s1_valid || s2_valid;
  assign common_status_byte = {~alert_driving_low, ~device_busy,
                               ~calc_pending, ~output_in_transition,
                               nvm_initialized, 1'b0,
                               shared_timebase_line_timeout,
                               write_protect_pin};             // RULE_01
  assign extended_info_word = 16'(ecc_clean) << INFO_ECC_BIT;  // RULE_02

  // ---------------------------------------------------------------
  // command read port
  // ---------------------------------------------------------------
  // answer one cycle after the read strobe; unknown codes return zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      read_data        <= WORD_RESET;
      read_valid       <= 1'b0;
      read_two_bytes   <= 1'b0;
      read_unsupported <= 1'b0;
    end else begin
      read_valid       <= cmd_read;
      read_unsupported <= 1'b0;
      read_two_bytes   <= 1'b1;                                // RULE_14
      if (cmd_read) begin
        unique case (cmd_code)
          CODE_INPUT_VOLTAGE:  read_data <= input_voltage_reading;
          CODE_INPUT_CURRENT:  read_data <= input_current_total;
          CODE_OUTPUT_VOLTAGE: read_data <= output_voltage_reading[cmd_page];
          CODE_OUTPUT_CURRENT: read_data <= output_current_reading[cmd_page];
          CODE_EXT_TEMP:       read_data <= external_temp_reading[cmd_page];
          CODE_INT_TEMP:       read_data <= internal_temp_reading;
          CODE_DUTY_CYCLE:     read_data <= duty_cycle_reading[cmd_page];
          CODE_OUTPUT_POWER:   read_data <= output_power_reading[cmd_page];
          CODE_IOUT_MAX:       read_data <= output_current_max[cmd_page];
          CODE_VOUT_MAX:       read_data <= output_voltage_max[cmd_page];
          CODE_VIN_MAX:        read_data <= input_voltage_max;
          CODE_EXT_TEMP_MAX:   read_data <= external_temp_max[cmd_page];
          CODE_CHANNEL_IIN:    read_data <= channel_input_current[cmd_page];
          CODE_INT_TEMP_MAX:   read_data <= internal_temp_max;
          CODE_EXTENDED_INFO:  read_data <= extended_info_word; // RULE_02
          CODE_COMMON_STATUS: begin
            read_data      <= {8'h00, common_status_byte};      // RULE_01
            read_two_bytes <= 1'b0;
          end
          default: begin
            read_data        <= WORD_RESET;
            read_unsupported <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule : power_telemetry_readback

// ---- logic/telemetry_pkg.sv ----
// constants shared by the power telemetry readback bank
package telemetry_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_INPUT_VOLTAGE   = 8'h88;
  localparam logic [7:0] CODE_INPUT_CURRENT   = 8'h89;
  localparam logic [7:0] CODE_OUTPUT_VOLTAGE  = 8'h8B;
  localparam logic [7:0] CODE_OUTPUT_CURRENT  = 8'h8C;
  localparam logic [7:0] CODE_EXT_TEMP        = 8'h8D;
  localparam logic [7:0] CODE_INT_TEMP        = 8'h8E;
  localparam logic [7:0] CODE_DUTY_CYCLE      = 8'h94;
  localparam logic [7:0] CODE_OUTPUT_POWER    = 8'h96;
  localparam logic [7:0] CODE_IOUT_MAX        = 8'hD7;
  localparam logic [7:0] CODE_VOUT_MAX        = 8'hDD;
  localparam logic [7:0] CODE_VIN_MAX         = 8'hDE;
  localparam logic [7:0] CODE_EXT_TEMP_MAX    = 8'hDF;
  localparam logic [7:0] CODE_CHANNEL_IIN     = 8'hED;
  localparam logic [7:0] CODE_INT_TEMP_MAX    = 8'hF4;
  localparam logic [7:0] CODE_COMMON_STATUS   = 8'hEF;
  localparam logic [7:0] CODE_EXTENDED_INFO   = 8'hE7;
  localparam logic [7:0] CODE_PEAK_CLEAR      = 8'hE3;

  // ---------------------------------------------------------------
  // status layouts and reset values
  // ---------------------------------------------------------------
  localparam int          INFO_ECC_BIT        = 5;
  localparam logic        ECC_CLEAN_RESET     = 1'b1;
  localparam logic [15:0] WORD_RESET          = 16'h0000;
  localparam logic [15:0] L11_SATURATE_POS    = 16'h7BFF;
  localparam logic [15:0] L11_SATURATE_NEG    = 16'h7C00;

  // ---------------------------------------------------------------
  // fixed point arithmetic
  // ---------------------------------------------------------------
  localparam int FIX_W        = 48;
  localparam int FIX_FRAC     = 16;
  localparam int L11_EXP_BIAS = 16;
  localparam int L11_MAX_SH   = 32;
  localparam int VOUT_FRAC    = 12;
  localparam logic signed [47:0] FIX_ONE      = 48'sh0000_0001_0000;
  localparam logic signed [47:0] PCT_RECIP    = 48'sh0000_0000_028F;
  localparam logic signed [47:0] REF_TEMP_FIX = 48'sh0000_001B_0000;
  localparam logic signed [47:0] OHM_PER_MILLI = 48'sh0000_0000_03E8;
  localparam logic signed [47:0] PPM_RECIP    = 48'sh0000_0000_0043;
  localparam int                 PPM_SHIFT    = 26;

  typedef logic signed [FIX_W-1:0]   fix_t;
  typedef logic signed [2*FIX_W-1:0] wide_t;

endpackage : telemetry_pkg

// ---- dv/telemetry_checker.sv ----
// port checker for the telemetry bank
module telemetry_checker
  import telemetry_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        cmd_read,
  input wire logic        cmd_send,
  input wire logic [7:0]  cmd_code,
  input wire logic        sample_valid,
  input wire logic        alert_driving_low,
  input wire logic        nvm_initialized,
  input wire logic        write_protect_pin,
  input wire logic [15:0] read_data,
  input wire logic        read_valid,
  input wire logic        read_two_bytes,
  input wire logic        read_unsupported
);
  // -------------------------------------------------------------
  // read port relations
  // -------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_read_answer: assert property (cmd_read |=> read_valid)
    else $error("read not answered one cycle later");
  chk_valid_cause: assert property (read_valid |-> $past(cmd_read))
    else $error("answer without a request");
  chk_unknown_zero: assert property (
    read_unsupported |-> read_valid && read_data == 16'h0000)
    else $error("refused answer not zero");
  chk_unknown_flag: assert property (
    cmd_read && cmd_code == 8'h00 |=> read_unsupported)
    else $error("unknown code not refused");
  chk_status_shape: assert property (
    cmd_read && cmd_code == CODE_COMMON_STATUS |=> !read_two_bytes
    && read_data[15:8] == 8'h00 && !read_data[2])
    else $error("status byte shape wrong");
  chk_status_bits: assert property (
    cmd_read && cmd_code == CODE_COMMON_STATUS |=>
    read_data[7] == !$past(alert_driving_low)
    && read_data[3] == $past(nvm_initialized)
    && read_data[0] == $past(write_protect_pin))
    else $error("status level bits wrong");
  chk_calc_pending: assert property (
    cmd_read && cmd_code == CODE_COMMON_STATUS && sample_valid
    |=> !read_data[5])
    else $error("pending calculation not shown");
  chk_info_layout: assert property (
    cmd_read && cmd_code == CODE_EXTENDED_INFO |=> read_two_bytes
    && read_data[15:6] == 10'h000 && read_data[4:0] == 5'h00)
    else $error("info word reserved bits set");
  chk_clear_zero: assert property (
    (cmd_send && cmd_code == CODE_PEAK_CLEAR && !$past(sample_valid)
    && !$past(sample_valid, 2)) ##1 (cmd_read && cmd_code == CODE_VIN_MAX)
    |=> read_data == 16'h0000)
    else $error("maximum not empty after clear");
endmodule : telemetry_checker

bind power_telemetry_readback telemetry_checker chk (
  .clock(clock), .rst_b(rst_b), .cmd_read(cmd_read), .cmd_send(cmd_send),
  .cmd_code(cmd_code), .sample_valid(sample_valid),
  .alert_driving_low(alert_driving_low), .nvm_initialized(nvm_initialized),
  .write_protect_pin(write_protect_pin), .read_data(read_data),
  .read_valid(read_valid), .read_two_bytes(read_two_bytes),
  .read_unsupported(read_unsupported));

// ---- dv/pmbus_host_model.sv ----
// host model issuing read and send commands
module pmbus_host_model
  import telemetry_pkg::*;
(
  input  wire logic       clock,
  output      logic       cmd_read,
  output      logic       cmd_send,
  output      logic [7:0] cmd_code,
  output      logic       cmd_page
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] req_q[$]; // read, send, page, code

  // one request per cycle; idle code and page toggle so no stale match
  always @(posedge clock) begin
    #1;
    if (req_q.size() > 0) begin
      {cmd_read, cmd_send, cmd_page, cmd_code} = req_q.pop_front();
    end else begin
      {cmd_read, cmd_send} = 2'b00;
      cmd_code = ~cmd_code;
      cmd_page = ~cmd_page;
    end
  end
endmodule : pmbus_host_model

// ---- dv/power_telemetry_readback_test.sv ----
// self-checking bench for the power telemetry readback bank
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module power_telemetry_readback_test
  import telemetry_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rst_b = 0, sample_valid = 0, ecc_no_corrections = 1;
  logic alert_driving_low = 0, device_busy = 0, output_in_transition = 0;
  logic nvm_initialized = 0, shared_timebase_line_timeout = 0;
  logic write_protect_pin = 0;
  logic [2:0] ev = 3'h0;
  logic [15:0] vin_sample = 0, int_temp_sample = 0, vmax, tmax, read_data;
  logic [1:0][15:0] vout_sample = 0, ext_diode_sample = 0, omax;
  logic [1:0][15:0] duty_sample = 0, vsense_sample = 0;
  logic [1:0][15:0] current_cal_gain = {2{16'h0001}};
  logic [1:0][15:0] current_gain_temp_coeff = 0, ext_temp_offset = 0;
  logic [1:0][15:0] ext_temp_gain = {2{16'h0001}};
  logic [1:0][15:0] input_current_offset = {16'h0005, 16'h0003};
  logic [1:0][4:0] vout_mode_exp = {5'h14, 5'h14}; // no shift on readback
  logic cmd_read, cmd_send, cmd_page, read_valid, read_two_bytes;
  logic read_unsupported;
  logic [7:0] cmd_code;
  logic [7:0] mx[5] = '{CODE_VIN_MAX, CODE_INT_TEMP_MAX, CODE_EXT_TEMP_MAX,
                        CODE_VOUT_MAX, CODE_IOUT_MAX};
  logic [18:0] exp_q[$]; // two-byte mask, refused, two-byte, data
  logic [18:0] e;
  int n_fail = 0, n_checks = 0, seed = 84075, k, j;

  always #4 clock = ~clock;

  pmbus_host_model host (.clock, .cmd_read, .cmd_send, .cmd_code, .cmd_page);
  power_telemetry_readback dut (.clock, .rst_b, .cmd_read, .cmd_send,
    .cmd_code, .cmd_page, .sample_valid, .vin_sample, .int_temp_sample,
    .vout_sample, .vsense_sample, .ext_diode_sample, .duty_sample,
    .current_cal_gain, .current_gain_temp_coeff, .ext_temp_gain,
    .ext_temp_offset, .input_current_offset, .vout_mode_exp,
    .alert_driving_low, .device_busy, .output_in_transition,
    .nvm_initialized, .shared_timebase_line_timeout, .write_protect_pin,
    .ecc_no_corrections, .restore_event(ev[0]), .reset_cmd_event(ev[1]),
    .bulk_read_event(ev[2]), .read_data, .read_valid, .read_two_bytes,
    .read_unsupported);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic rd(logic [7:0] c, logic p, logic [15:0] d, logic [2:0] f);
    exp_q.push_back({f, d});
    host.req_q.push_back({2'b10, p, c});
  endtask : rd
  task automatic sd(logic [7:0] c);
    host.req_q.push_back({2'b01, 1'b0, c});
  endtask : sd
  task automatic pulse();
    sample_valid = 1'b1;
    @(posedge clock); #1;
    sample_valid = 1'b0;
    // readings land two edges after the take; read one edge later
    repeat (2) @(posedge clock); #1;
  endtask : pulse
  // bounded wait for all answers
  task automatic drain();
    int i;
    for (i = 0; i < 60 && host.req_q.size() + exp_q.size() > 0; i++)
      @(posedge clock);
    if (i == 60) begin
      n_fail++;
      $display("Error at %0t: answers missing", $time);
      tally_and_finish();
    end
    @(posedge clock); #1;
  endtask : drain
  function automatic logic [15:0] st(logic calc_idle);
    return {8'h00, ~alert_driving_low, ~device_busy, calc_idle,
      ~output_in_transition, nvm_initialized, 1'b0,
      shared_timebase_line_timeout, write_protect_pin};
  endfunction : st
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // answer monitor
  always @(negedge clock) begin
    if (read_valid === 1'b1) begin
      `CHK(exp_q.size() != 0, 1'b1)
      e = exp_q.pop_front();
      `CHK(read_data, e[15:0])
      `CHK(read_unsupported, e[17])
      if (!e[18]) `CHK(read_two_bytes, e[16])
    end
  end

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_b = 1'b1;
    rd(CODE_EXTENDED_INFO, 0, 16'h0020, 3'b001);
    drain();
    for (k = 0; k < 3; k++) begin
      ecc_no_corrections = ~ecc_no_corrections;
      rd(CODE_EXTENDED_INFO, 0, {10'h0, ~ecc_no_corrections, 5'h0}, 1);
      drain();
      ev[k] = 1'b1;
      @(posedge clock); #1;
      ev[k] = 1'b0;
      rd(CODE_EXTENDED_INFO, 0, {10'h0, ecc_no_corrections, 5'h0}, 1);
      drain();
    end
    $display("ecc flag test done");
    {vmax, tmax, omax} = 0;
    for (k = 0; k < 6; k++) begin
      {alert_driving_low, device_busy, output_in_transition, nvm_initialized,
       shared_timebase_line_timeout, write_protect_pin} = 6'($random(seed));
      vin_sample = {6'h3C, 10'($random(seed))};
      int_temp_sample = {6'h3E, 10'($random(seed))};
      {vout_sample, duty_sample} = {$random(seed), $random(seed)};
      ext_diode_sample = $random(seed);
      vmax = (vin_sample > vmax) ? vin_sample : vmax;
      tmax = (int_temp_sample > tmax) ? int_temp_sample : tmax;
      rd(CODE_COMMON_STATUS, 0, st(1'b0), 3'b000);
      pulse();
      rd(CODE_INPUT_VOLTAGE, 0, vin_sample, 1);
      rd(CODE_VIN_MAX, 0, vmax, 1);
      rd(CODE_INT_TEMP, 0, int_temp_sample, 1);
      rd(CODE_INT_TEMP_MAX, 0, tmax, 1);
      rd(CODE_INPUT_CURRENT, 0, 16'hD200, 1);
      for (j = 0; j < 2; j++) begin
        omax[j] = (vout_sample[j] > omax[j]) ? vout_sample[j] : omax[j];
        rd(CODE_OUTPUT_VOLTAGE, j[0], vout_sample[j], 1);
        rd(CODE_VOUT_MAX, j[0], omax[j], 1);
        rd(CODE_DUTY_CYCLE, j[0], duty_sample[j], 1);
        rd(CODE_CHANNEL_IIN, j[0], j ? 16'hCA80 : 16'hC300, 1);
      end
      drain();
      rd(CODE_COMMON_STATUS, 0, st(1'b1), 3'b000);
      drain();
    end
    $display("telemetry test done");
    sd(8'hE4);
    rd(CODE_VIN_MAX, 0, vmax, 1);
    sd(CODE_PEAK_CLEAR);
    for (j = 0; j < 10; j++)
      rd(mx[j % 5], j / 5, 16'h0000, 1);
    drain();
    vin_sample = 16'hF001;
    pulse();
    rd(CODE_VIN_MAX, 0, 16'hF001, 1);
    drain();
    $display("peak clear test done");
    rd(8'h00, 0, 16'h0000, 3'b110);
    rd(8'hFF, 1, 16'h0000, 3'b110);
    drain();
    $display("refusal test done");
    tally_and_finish();
  end
endmodule : power_telemetry_readback_test
